// >>> design/src_ctrl.sv
module src_ctrl
	import src_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic [1:0] arm_level,
	input wire logic [1:0] pretrigger_level,
	input wire logic [1:0] turn_on_sense_current,
	input wire logic [1:0] turn_off_level,
	input wire logic [1:0] zero_cross,
	output logic [1:0] gate,
	output logic sleep_mode
);
	typedef enum logic [1:0] {
		SRC_IDLE = 2'b00,
		SRC_DEBOUNCE = 2'b01,
		SRC_ON = 2'b10,
		SRC_DONE = 2'b11
	} src_state_type;

	src_sense_type raw [2];
	src_sense_type sense [2];
	src_meas_type meas [2];
	src_state_type state_ff [2];
	src_state_type nxt_state [2];
	logic [DW-1:0] deb_ff [2];
	logic [TW-1:0] on_ff [2];
	logic [TW-1:0] half_ff [2];
	logic [1:0] half_ok_ff;
	logic [1:0] armed_ff;
	logic [1:0] arm_d_ff;
	logic [1:0] withhold_ff;
	logic [1:0] gate_ff;
	logic [CW-1:0] sleep_cnt_ff [2];
	logic [CW-1:0] wake_cnt_ff [2];
	logic [1:0] rev_cnt_ff [2];
	logic [HW-1:0] hold_ff;
	logic sleep_ff;
	logic go_sleep;
	logic go_wake;
	logic [1:0] gate_off_req;

	function automatic logic below_pct(input logic [TW-1:0] part, input logic [TW-1:0] whole,
		input int pct);
		logic [TW+7:0] lhs;
		logic [TW+7:0] rhs;
		lhs = 24'(part) * 24'(PCT_FULL);
		rhs = 24'(whole) * 24'(pct);
		return lhs < rhs;
	endfunction

	function automatic logic above_pct(input logic [TW-1:0] part, input logic [TW-1:0] whole,
		input int pct);
		logic [TW+7:0] lhs;
		logic [TW+7:0] rhs;
		lhs = 24'(part) * 24'(PCT_FULL);
		rhs = 24'(whole) * 24'(pct);
		return lhs > rhs;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			assign raw[g] = '{arm: arm_level[g], pretrig: pretrigger_level[g],
				on_det: turn_on_sense_current[g], off_th: turn_off_level[g],
				zero_x: zero_cross[g]};
			src_sync u_sync (
				.clk(clk),
				.sys_rst(sys_rst),
				.raw(raw[g]),
				.synced(sense[g])
			);
			src_meas u_meas (
				.clk(clk),
				.sys_rst(sys_rst),
				.sense(sense[g]),
				.gate_on(gate_ff[g]),
				.meas(meas[g])
			);
		end
	endgenerate

	// Turn-off cause per channel
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			gate_off_req[c] = sense[c].zero_x
				// No mask before a cycle is measured, else the first gate never drops
				| ((~half_ok_ff[c] | on_ff[c] >= half_ff[c]) & sense[c].off_th);
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			nxt_state[c] = state_ff[c];
			unique case (state_ff[c])
				SRC_IDLE: begin
					if (sense[c].on_det & armed_ff[c] & ~withhold_ff[c] & ~sleep_ff) begin
						nxt_state[c] = SRC_DEBOUNCE;
					end
				end
				SRC_DEBOUNCE: begin
					if (~sense[c].on_det) begin
						nxt_state[c] = SRC_IDLE;
					end else if (deb_ff[c] == DEBOUNCE_CNT - 8'h01 & ~gate_ff[1-c]) begin
						nxt_state[c] = SRC_ON;
					end
				end
				SRC_ON: begin
					if (gate_off_req[c]) begin
						nxt_state[c] = SRC_DONE;
					end
				end
				// Waits for re-arm by the opposite side; diode re-crossing ignored
				SRC_DONE: begin
					if (armed_ff[c]) begin
						nxt_state[c] = SRC_IDLE;
					end
				end
			endcase
			if (sleep_ff | ~enable) begin
				if (state_ff[c] != SRC_IDLE) begin
					nxt_state[c] = SRC_DONE;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff[0] <= SRC_IDLE;
			state_ff[1] <= SRC_IDLE;
		end else begin
			state_ff[0] <= nxt_state[0];
			state_ff[1] <= nxt_state[1];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			deb_ff[0] <= '0;
			deb_ff[1] <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				deb_ff[c] <= (state_ff[c] == SRC_DEBOUNCE) ? deb_ff[c] + 8'h01 : 8'h00;
			end
		end
	end

	// Gate only from the on state; enable drops it in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gate_ff <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				gate_ff[c] <= (nxt_state[c] == SRC_ON) & enable & ~sleep_ff;
			end
		end
	end

	// Sleep entry may land while the other side is on: drop it at once
	assign gate = gate_ff & {2{enable & ~sleep_ff}};
	assign sleep_mode = sleep_ff;

	// Arming: the opposite channel's drain rising sets our permission
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			arm_d_ff <= 2'b00;
			armed_ff <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				arm_d_ff[c] <= sense[c].arm;
				if (sense[1-c].arm & ~arm_d_ff[1-c]) begin
					armed_ff[c] <= 1'b1;
				end else if (nxt_state[c] == SRC_ON | nxt_state[c] == SRC_DONE) begin
					armed_ff[c] <= 1'b0;
				end
			end
		end
	end

	// Balance: a cycle measured without drive withholds the other side once
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			withhold_ff <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				// A withheld cycle does not pass the miss on, or both sides lock out
				if (meas[1-c].valid & ~meas[1-c].drove & ~withhold_ff[1-c] & ~sleep_ff
					& enable) begin
					withhold_ff[c] <= 1'b1;
				end else if (meas[c].valid) begin
					withhold_ff[c] <= 1'b0;
				end
			end
		end
	end

	// Conduction timer and half-point from the last cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			on_ff[0] <= TIMER_ZERO;
			on_ff[1] <= TIMER_ZERO;
			half_ff[0] <= TIMER_ZERO;
			half_ff[1] <= TIMER_ZERO;
			half_ok_ff <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				on_ff[c] <= gate_ff[c] ? on_ff[c] + 16'h0001 : TIMER_ZERO;
				if (meas[c].valid) begin
					half_ff[c] <= meas[c].cycle >> 1;
					half_ok_ff[c] <= 1'b1;
				end
			end
		end
	end

	// Sleep decisions
	assign go_sleep = (sleep_cnt_ff[0] >= CW'(SLEEP_CONFIRM) & sleep_cnt_ff[1] >= CW'(SLEEP_CONFIRM))
		| (rev_cnt_ff[0] >= 2'(REV_CONFIRM)) | (rev_cnt_ff[1] >= 2'(REV_CONFIRM));
	assign go_wake = wake_cnt_ff[0] >= CW'(WAKE_CONFIRM)
		& wake_cnt_ff[1] >= CW'(WAKE_CONFIRM);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int c = 0; c < 2; c++) begin
				sleep_cnt_ff[c] <= CNT_ZERO;
				wake_cnt_ff[c] <= CNT_ZERO;
				rev_cnt_ff[c] <= 2'b00;
			end
		end else if ((~sleep_ff & go_sleep) | (sleep_ff & go_wake)) begin
			for (int c = 0; c < 2; c++) begin
				sleep_cnt_ff[c] <= CNT_ZERO;
				wake_cnt_ff[c] <= CNT_ZERO;
				rev_cnt_ff[c] <= 2'b00;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (meas[c].valid) begin
					// Counters saturate; sleep and wake counters are held at zero during the hold-off
					if (hold_ff != HOLD_ZERO) begin
						sleep_cnt_ff[c] <= CNT_ZERO;
						wake_cnt_ff[c] <= CNT_ZERO;
					end else if (~sleep_ff) begin
						sleep_cnt_ff[c] <= below_pct(meas[c].cond, meas[c].cycle, SLEEP_PCT)
							? ((sleep_cnt_ff[c] == CW'(SLEEP_CONFIRM)) ? sleep_cnt_ff[c]
							: sleep_cnt_ff[c] + 5'h01) : CNT_ZERO;
					end else begin
						wake_cnt_ff[c] <= above_pct(meas[c].cond, meas[c].cycle, WAKE_PCT)
							? ((wake_cnt_ff[c] == CW'(WAKE_CONFIRM)) ? wake_cnt_ff[c]
							: wake_cnt_ff[c] + 5'h01) : CNT_ZERO;
					end
					if (~sleep_ff) begin
						rev_cnt_ff[c] <= meas[c].reversal
							? ((rev_cnt_ff[c] == 2'(REV_CONFIRM)) ? rev_cnt_ff[c]
							: rev_cnt_ff[c] + 2'b01) : 2'b00;
					end
				end
			end
		end
	end

	// Hold-off counts converter cycles, stepped on channel 0 cycle ends
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_ff <= 1'b0;
			hold_ff <= HOLD_ZERO;
		end else if (~sleep_ff & go_sleep) begin
			sleep_ff <= 1'b1;
			hold_ff <= HW'(HOLD_AFTER_SLEEP);
		end else if (sleep_ff & go_wake) begin
			sleep_ff <= 1'b0;
			hold_ff <= HW'(HOLD_AFTER_WAKE);
		end else if (meas[0].valid & hold_ff != HOLD_ZERO) begin
			hold_ff <= hold_ff - 9'h001;
		end
	end

	property p_no_overlap;
		@(posedge clk) disable iff (sys_rst) !(gate[0] && gate[1]);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

	property p_enable_off;
		@(posedge clk) disable iff (sys_rst) !enable |-> gate == 2'b00;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("gate on while disabled");

	property p_sleep_off;
		@(posedge clk) disable iff (sys_rst) sleep_ff |=> gate_ff == 2'b00;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("gate on in sleep");

	property p_debounce;
		@(posedge clk) disable iff (sys_rst) $rose(gate_ff[0]) |->
			$past(sense[0].on_det, 60) && $past(sense[0].on_det, 2);
	endproperty
	a_debounce: assert property (p_debounce) else $error("turn-on debounce short");

	property p_armed;
		@(posedge clk) disable iff (sys_rst) $rose(gate_ff[1]) |-> $past(armed_ff[1], 2);
	endproperty
	a_armed: assert property (p_armed) else $error("turn-on without arm");

	property p_off_once;
		@(posedge clk) disable iff (sys_rst) $fell(gate_ff[0]) && enable && !sleep_ff
			|-> !armed_ff[0];
	endproperty
	a_off_once: assert property (p_off_once) else $error("re-armed at turn-off");

	property p_half_mask;
		@(posedge clk) disable iff (sys_rst) state_ff[0] == SRC_ON && !sense[0].zero_x
			&& half_ok_ff[0] && on_ff[0] < half_ff[0] && enable && !sleep_ff
			|=> state_ff[0] == SRC_ON;
	endproperty
	a_half_mask: assert property (p_half_mask) else $error("early turn-off");

	property p_sleep_entry_hold;
		@(posedge clk) disable iff (sys_rst) $rose(sleep_ff) |-> hold_ff == HW'(HOLD_AFTER_SLEEP);
	endproperty
	a_sleep_entry_hold: assert property (p_sleep_entry_hold) else $error("bad hold");

	property p_wake_cnt;
		@(posedge clk) disable iff (sys_rst) $fell(sleep_ff) |->
			$past(wake_cnt_ff[0]) >= CW'(WAKE_CONFIRM) && $past(wake_cnt_ff[1]) >= CW'(WAKE_CONFIRM);
	endproperty
	a_wake_cnt: assert property (p_wake_cnt) else $error("early wake");
endmodule // src_ctrl

// >>> design/src_pkg.sv
package src_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int DEBOUNCE_TIME_NS = 250;
	// Strictly longer than 250 ns: one count more than the rounded-up figure
	localparam int DEBOUNCE_CYC = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int TW = 16;
	localparam int DW = 8;
	localparam logic [DW-1:0] DEBOUNCE_CNT = DW'(DEBOUNCE_CYC);
	localparam logic [TW-1:0] TIMER_MAX = 16'hFFFF;
	localparam logic [TW-1:0] TIMER_ZERO = 16'h0000;
	localparam int SLEEP_PCT = 40;
	localparam int WAKE_PCT = 60;
	localparam int PCT_FULL = 100;
	localparam int SLEEP_CONFIRM = 16;
	localparam int WAKE_CONFIRM = 8;
	localparam int HOLD_AFTER_SLEEP = 128;
	localparam int HOLD_AFTER_WAKE = 256;
	localparam int REV_CONFIRM = 2;
	localparam int CW = 5;
	localparam int HW = 9;
	localparam logic [CW-1:0] CNT_ZERO = 5'h00;
	localparam logic [HW-1:0] HOLD_ZERO = 9'h000;

	typedef struct packed {
		logic arm;
		logic pretrig;
		logic on_det;
		logic off_th;
		logic zero_x;
	} src_sense_type;

	typedef struct packed {
		logic valid;
		logic [TW-1:0] cycle;
		logic [TW-1:0] cond;
		logic drove;
		logic reversal;
	} src_meas_type;
endpackage

// >>> design/src_sync.sv
module src_sync
	import src_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire src_sense_type raw,
	output src_sense_type synced
);
	src_sense_type meta_ff;
	src_sense_type sync_ff;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= raw;
			sync_ff <= meta_ff;
		end
	end

	assign synced = sync_ff;
endmodule // src_sync

// >>> design/src_meas.sv
module src_meas
	import src_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input src_sense_type sense,
	input wire logic gate_on,
	output src_meas_type meas
);
	logic arm_d_ff;
	logic pt_d_ff;
	logic on_d_ff;
	logic gate_d_ff;
	logic cyc_run_ff;
	logic cond_run_ff;
	logic drove_ff;
	logic rev_ff;
	logic [TW-1:0] cyc_ff;
	logic [TW-1:0] cond_ff;
	src_meas_type meas_ff;
	logic pt_fall;
	logic arm_rise;
	logic cond_end;

	function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
		return (v == TIMER_MAX) ? v : v + 16'h0001;
	endfunction

	assign pt_fall = pt_d_ff & ~sense.pretrig;
	assign arm_rise = ~arm_d_ff & sense.arm;
	// Driving: ends on gate release; otherwise body diode stops
	assign cond_end = cond_run_ff & (drove_ff ? (gate_d_ff & ~gate_on)
		: (on_d_ff & ~sense.on_det));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			arm_d_ff <= 1'b0;
			pt_d_ff <= 1'b0;
			on_d_ff <= 1'b0;
			gate_d_ff <= 1'b0;
		end else begin
			arm_d_ff <= sense.arm;
			pt_d_ff <= sense.pretrig;
			on_d_ff <= sense.on_det;
			gate_d_ff <= gate_on;
		end
	end

	// Cycle from pretrigger fall, closed at arm rise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc_run_ff <= 1'b0;
			cyc_ff <= TIMER_ZERO;
		end else if (pt_fall) begin
			cyc_run_ff <= 1'b1;
			cyc_ff <= TIMER_ZERO;
		end else if (arm_rise) begin
			cyc_run_ff <= 1'b0;
		end else if (cyc_run_ff) begin
			cyc_ff <= sat_inc(cyc_ff);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_run_ff <= 1'b0;
			cond_ff <= TIMER_ZERO;
			drove_ff <= 1'b0;
			rev_ff <= 1'b0;
		end else if (pt_fall) begin
			cond_run_ff <= 1'b0;
			cond_ff <= TIMER_ZERO;
			drove_ff <= 1'b0;
			rev_ff <= 1'b0;
		end else begin
			if (~on_d_ff & sense.on_det & ~cond_run_ff & cond_ff == TIMER_ZERO) begin
				cond_run_ff <= 1'b1;
			end else if (cond_end) begin
				cond_run_ff <= 1'b0;
			end
			if (cond_run_ff & ~cond_end) begin
				cond_ff <= sat_inc(cond_ff);
			end
			if (gate_on) begin
				drove_ff <= 1'b1;
			end
			// Current about to reverse while conducting
			if (cond_run_ff & sense.zero_x) begin
				rev_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meas_ff <= '0;
		end else begin
			meas_ff.valid <= arm_rise & cyc_run_ff;
			if (arm_rise & cyc_run_ff) begin
				meas_ff.cycle <= cyc_ff;
				meas_ff.cond <= cond_ff;
				meas_ff.drove <= drove_ff;
				meas_ff.reversal <= rev_ff;
			end
		end
	end

	assign meas = meas_ff;
endmodule // src_meas

// >>> dv/src_drain_model.sv
module src_drain_model (
	input wire logic clk,
	input wire logic [1:0] gate,
	output logic [1:0] arm_level,
	output logic [1:0] pretrigger_level,
	output logic [1:0] turn_on_sense_current,
	output logic [1:0] turn_off_level,
	output logic [1:0] zero_cross
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		arm_level = 2'b11;
		pretrigger_level = 2'b11;
		turn_on_sense_current = 2'b00;
		turn_off_level = 2'b00;
		zero_cross = 2'b00;
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// One low drain phase; mode 1 trips turn-off early, mode 2 signals reversal
	task automatic half(input int c, input int t, input int cond, input int mode,
			output bit stay, output int lat);
		int gon;
		int zn;
		int k;
		stay = 1'b1;
		lat = -1;
		gon = 0;
		zn = 0;
		arm_level[c] = 1'b0;
		pretrigger_level[c] = 1'b0;
		step();
		step();
		turn_on_sense_current[c] = 1'b1;
		for (k = 0; k < cond; k++) begin
			step();
			if (gate[c] === 1'b1)
				gon++;
			turn_off_level[c] = (mode == 1 && gon >= 20 && gon < 40);
			if (turn_off_level[c] && gate[c] !== 1'b1)
				stay = 1'b0;
			if (mode == 2 && gon == 20 && lat < 0)
				zero_cross[c] = 1'b1;
			if (zero_cross[c] === 1'b1) begin
				zn++;
				if (gate[c] !== 1'b1 || zn > 20) begin
					lat = zn;
					zero_cross[c] = 1'b0;
				end
			end
		end
		if (gate[c] === 1'b1) begin
			turn_off_level[c] = 1'b1;
			for (zn = 1; zn <= 20 && lat < 0; zn++) begin
				step();
				if (gate[c] !== 1'b1)
					lat = zn;
			end
			if (lat < 0)
				lat = 21;
			turn_off_level[c] = 1'b0;
		end
		// Diode keeps conducting after turn-off, a false trigger source
		repeat (4) step();
		turn_on_sense_current[c] = 1'b0;
		for (k = cond + 6; k < t; k++)
			step();
		arm_level[c] = 1'b1;
		pretrigger_level[c] = 1'b1;
		step();
	endtask
endmodule // src_drain_model

// >>> dv/sync_rectifier_gate_control_tb_top.sv
module sync_rectifier_gate_control_tb_top;
	import src_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic sys_rst;
	logic enable;
	logic [1:0] arm_level;
	logic [1:0] pretrigger_level;
	logic [1:0] turn_on_sense_current;
	logic [1:0] turn_off_level;
	logic [1:0] zero_cross;
	logic [1:0] gate;
	logic sleep_mode;
	logic [1:0] gate_q;
	logic sleep_q;
	logic watch;
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 32'h0e8b;
	int on_run [2];
	int exp_q [$];

	always #2 clk = ~clk;

	src_ctrl uut (.clk(clk), .sys_rst(sys_rst), .enable(enable), .arm_level(arm_level),
		.pretrigger_level(pretrigger_level), .turn_on_sense_current(turn_on_sense_current),
		.turn_off_level(turn_off_level), .zero_cross(zero_cross), .gate(gate),
		.sleep_mode(sleep_mode));

	src_drain_model partner (.clk(clk), .gate(gate), .arm_level(arm_level),
		.pretrigger_level(pretrigger_level), .turn_on_sense_current(turn_on_sense_current),
		.turn_off_level(turn_off_level), .zero_cross(zero_cross));

	task automatic chk(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Events: 0/1 gate rise, 2 sleep entry, 3 sleep exit
	task automatic note(input int ev);
		if (!watch)
			return;
		chk(exp_q.size() > 0 && exp_q[0] == ev, "unexpected gate or sleep event");
		if (exp_q.size() > 0)
			void'(exp_q.pop_front());
	endtask

	always @(negedge clk) begin
		if (sys_rst) begin
			gate_q = 2'b00;
			sleep_q = 1'b0;
		end else begin
			chk(!(gate[0] === 1'b1 && gate[1] === 1'b1), "both gates on");
			if (enable === 1'b0)
				chk(gate === 2'b00, "gate on while disabled");
			if (sleep_mode === 1'b1)
				chk(gate === 2'b00, "gate on while asleep");
			for (int c = 0; c < 2; c++) begin
				on_run[c] = (turn_on_sense_current[c] === 1'b1) ? on_run[c] + 1 : 0;
				if (gate[c] === 1'b1 && gate_q[c] !== 1'b1) begin
					// Less two sync stages, the gate register and the first count
					chk((on_run[c] - 4) * CLK_PERIOD_NS > DEBOUNCE_TIME_NS, "gate before debounce");
					note(c);
				end
			end
			if (sleep_mode !== sleep_q)
				note(sleep_mode === 1'b1 ? 2 : 3);
			gate_q = gate;
			sleep_q = sleep_mode;
		end
	end

	task automatic run(input int c, input int t, input int cond, input int mode, input bit drv);
		bit stay;
		int lat;
		if (drv)
			exp_q.push_back(c);
		partner.half(c, t, cond, mode, stay, lat);
		if (drv)
			chk(lat >= 1 && lat <= 8, "turn-off latency");
		if (mode == 1)
			chk(stay, "early turn-off honoured");
	endtask

	task automatic npair(input bit drv);
		int t;
		for (int c = 0; c < 2; c++) begin
			t = 300 + ($random(seed) & 31);
			run(c, t, t - 30, 0, drv);
		end
	endtask

	// Warm-up gives two measured cycles on channel 0 and three on channel 1 so the half-cycle mask is known
	task automatic restart();
		watch = 1'b0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		chk(gate === 2'b00 && sleep_mode === 1'b0, "state after reset");
		repeat (3) npair(1'b0);
		exp_q.delete();
		watch = 1'b1;
	endtask

	task automatic settle(input string name);
		repeat (4) @(posedge clk);
		#1;
		chk(exp_q.size() == 0, "expected gate or sleep event missing");
		exp_q.delete();
		$display("test %s finished", name);
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		chk(1'b0, "run exceeded its cycle limit");
		end_sim();
	end

	initial begin
		int k;
		sys_rst = 1'b1;
		enable = 1'b1;
		watch = 1'b0;
		restart();
		run(0, 300, 40 + ($random(seed) & 15), 0, 1'b0);
		run(1, 300, 270, 0, 1'b0);
		run(0, 300, 270, 0, 1'b1);
		settle("debounce");
		restart();
		run(0, 300, 270, 1, 1'b1);
		run(1, 300, 270, 2, 1'b1);
		settle("mask");
		restart();
		run(0, 300, 270, 0, 1'b1);
		run(0, 300, 270, 0, 1'b0);
		settle("interlock");
		restart();
		enable = 1'b0;
		npair(1'b0);
		enable = 1'b1;
		settle("enable");
		restart();
		for (k = 0; k < 30; k++)
			run(k % 2, 140, 28, 0, 1'b0);
		chk(sleep_mode === 1'b0, "sleep before enough cycles");
		exp_q.push_back(2);
		for (k = 0; k < 4; k++)
			run(k % 2, 140, 28, 0, 1'b0);
		chk(sleep_mode === 1'b1, "no sleep entry");
		settle("sleep entry");
		exp_q.push_back(3);
		// Diode held 60 cycles: a wake candidate, but too short to debounce
		for (k = 0; k < 340 && sleep_mode === 1'b1; k++)
			run(k % 2, 80, 56, 0, 1'b0);
		chk(k > 250, "woke during hold-off");
		chk(sleep_mode === 1'b0, "no wake");
		watch = 1'b0;
		repeat (3) npair(1'b0);
		exp_q.delete();
		watch = 1'b1;
		npair(1'b1);
		settle("sleep exit");
		restart();
		run(0, 300, 270, 2, 1'b1);
		run(1, 300, 270, 2, 1'b1);
		exp_q.push_back(0);
		exp_q.push_back(2);
		run(0, 300, 270, 2, 1'b0);
		run(1, 300, 270, 0, 1'b0);
		chk(sleep_mode === 1'b1, "no sleep after reversal");
		settle("reversal");
		end_sim();
	end
endmodule // sync_rectifier_gate_control_tb_top
